// [spi_frame_pkg.sv]
////////////////////////////////////////////////////////////////////////////////
// Purpose: shared constants, types and the response checksum for the SPI framing-error block
// Assumes: 200 MHz system clock; serial addresses are byte addresses, registers are 16-bit words
// Notes: checksum polynomial and seed are plain defaults
////////////////////////////////////////////////////////////////////////////////
package spi_frame_pkg;

    localparam int CLOCK_MHZ = 200;
    localparam int STRAY_WINDOW_NS = 70;
    // longest time, so it rounds down
    localparam int STRAY_WINDOW_CYCLES = (STRAY_WINDOW_NS * CLOCK_MHZ) / 1000;

    localparam logic [5:0] NOP_ADDR = 6'h00;
    localparam logic [5:0] ERROR_STATUS_HI_ADDR = 6'h24;
    localparam logic [5:0] ERROR_STATUS_LO_ADDR = 6'h25;

    localparam int REG_ID_LSB = 12;
    localparam int FLAG_WIDTH = 12;
    localparam int IER_BIT = 9;
    localparam int CRC_FLAG_BIT = 8;
    localparam logic [11:0] FLAGS_RESET = 12'h000;

    // packet field positions inside the 16-bit command word
    localparam int SYNC_BIT = 15;
    localparam int RW_BIT = 14;
    localparam int ADDR_LSB = 8;
    localparam logic RW_WRITE = 1'b1;

    localparam logic [4:0] LEN16 = 5'h10;
    localparam logic [4:0] LEN20 = 5'h14;
    localparam logic [4:0] LEN21 = 5'h15;
    localparam logic [4:0] EDGE_MAX = 5'h1f;

    localparam logic [3:0] CRC_POLY = 4'h3;
    localparam logic [3:0] CRC_SEED = 4'hf;

    typedef enum logic [1:0] {
        FMT_POWERUP = 2'b00,
        FMT_16 = 2'b01,
        FMT_20 = 2'b10,
        FMT_21 = 2'b11
    } format_type;

    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_FRAME = 2'b01,
        LINK_SETTLE = 2'b10
    } link_state_type;

    typedef struct packed {
        logic write;
        logic [5:0] addr;
        logic [7:0] data;
    } command_type;

    function automatic logic [3:0] crc4(input logic [15:0] data);
        logic [3:0] c;
        logic fb;
        c = CRC_SEED;
        for (int i = 15; i >= 0; i--) begin
            fb = c[3] ^ data[i];
            c = {c[2:0], 1'b0};
            if (fb) begin
                c = c ^ CRC_POLY;
            end
        end
        return c;
    endfunction

endpackage

// [pin_sync.sv]
////////////////////////////////////////////////////////////////////////////////
// Purpose: two-flop synchroniser for a group of asynchronous pins
// Assumes: each bit is an independent level
// Notes: the first stage feeds only the second stage
////////////////////////////////////////////////////////////////////////////////
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    initial begin
        if (WIDTH < 1) begin
            $error("pin_sync needs at least one bit");
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta <= RESET_VALUE;
            q <= RESET_VALUE;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// [spi_frame_error_detect.sv]
////////////////////////////////////////////////////////////////////////////////
// Purpose: SPI slave frame checker with the error status word, 16/20/21-bit packets
// Assumes: SCLK idles high, MOSI sampled on SCLK rise, MISO changes on SCLK fall
// Notes: pins are oversampled by CLOCK; SCLK must stay well below CLOCK/4
////////////////////////////////////////////////////////////////////////////////
module spi_frame_error_detect #(
    // register identifier value is arbitrary
    parameter logic [3:0] REGISTER_ID = 4'h0
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic MOSI,
    input wire logic CRC_CHECK_EN,
    input wire logic [11:0] FLAG_EVENTS,
    output logic MISO,
    output logic MISO_OE,
    output logic [15:0] ERROR_STATUS,
    output logic FRAMING_ERROR
);
    localparam int SETTLE_W = $clog2(spi_frame_pkg::STRAY_WINDOW_CYCLES + 1);
    localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(spi_frame_pkg::STRAY_WINDOW_CYCLES);
    localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(1);
    localparam logic [SETTLE_W-1:0] AGE_LAST = SETTLE_W'(spi_frame_pkg::STRAY_WINDOW_CYCLES - 1);

    initial begin
        if (spi_frame_pkg::STRAY_WINDOW_CYCLES < 1) begin
            $error("stray window must be at least one cycle");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin sampling and edge detection

    logic [2:0] pins_s;
    logic sclk_s;
    logic cs_n_s;
    logic mosi_s;
    logic sclk_d;
    logic cs_d;

    pin_sync #(.WIDTH(3), .RESET_VALUE(3'h6)) u_pin_sync (
        .clock(CLOCK),
        .rst_n(RST_N),
        .d({SCLK, CS_N, MOSI}),
        .q(pins_s)
    );

    assign sclk_s = pins_s[2];
    assign cs_n_s = pins_s[1];
    assign mosi_s = pins_s[0];

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            sclk_d <= 1'b1;
            cs_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            cs_d <= cs_n_s;
        end
    end

    logic fall;
    logic rise;
    logic frame_start;
    logic frame_end;
    logic selected;
    logic stray_fall;
    spi_frame_pkg::format_type format;

    assign fall = sclk_d & ~sclk_s;
    assign rise = ~sclk_d & sclk_s;
    assign frame_start = cs_d & ~cs_n_s;
    assign frame_end = ~cs_d & cs_n_s;
    assign selected = ~cs_n_s;
    // the 21-bit format stops the counter while deselected
    assign stray_fall = fall & cs_n_s & cs_d & (format != spi_frame_pkg::FMT_21);

    ////////////////////////////////////////////////////////////////////////////
    // in-frame counting and receive shifter

    logic [4:0] frame_edges;
    logic [4:0] stray_edges;
    logic [20:0] rx;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            frame_edges <= 5'h00;
        end else if (frame_start) begin
            frame_edges <= 5'h00;
        end else if (selected && fall && frame_edges != spi_frame_pkg::EDGE_MAX) begin
            frame_edges <= frame_edges + 5'h01;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rx <= 21'h000000;
        end else if (frame_start) begin
            rx <= 21'h000000;
        end else if (selected && rise) begin
            rx <= {rx[19:0], mosi_s};
        end
    end

    // edges seen while deselected are charged to this die's next frame
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            stray_edges <= 5'h00;
        end else if (frame_end) begin
            stray_edges <= 5'h00;
        end else if (stray_fall && stray_edges != spi_frame_pkg::EDGE_MAX) begin
            stray_edges <= stray_edges + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame evaluation at deselect

    logic [15:0] packet;
    logic [3:0] crc_rx;
    logic tail_bad;
    logic len_ok;
    spi_frame_pkg::format_type new_format;
    logic crc_ok;
    logic spurious;
    logic frame_bad;
    logic cmd_ok;
    logic crc_bad;
    spi_frame_pkg::command_type cmd;

    always_comb begin
        packet = 16'h0000;
        crc_rx = 4'h0;
        tail_bad = 1'b0;
        len_ok = 1'b1;
        new_format = format;
        case (frame_edges)
            spi_frame_pkg::LEN16: begin
                packet = rx[15:0];
                new_format = spi_frame_pkg::FMT_16;
            end
            spi_frame_pkg::LEN20: begin
                packet = rx[19:4];
                crc_rx = rx[3:0];
                new_format = spi_frame_pkg::FMT_20;
            end
            spi_frame_pkg::LEN21: begin
                // the trailing zero pushes the 20-bit frame up one place
                packet = rx[20:5];
                crc_rx = rx[4:1];
                tail_bad = rx[0];
                new_format = spi_frame_pkg::FMT_21;
            end
            default: begin
                len_ok = 1'b0;
            end
        endcase
    end

    assign crc_ok = (frame_edges == spi_frame_pkg::LEN16) || (spi_frame_pkg::crc4(packet) == crc_rx);
    assign spurious = (format == spi_frame_pkg::FMT_POWERUP) && (stray_edges != 5'h00);
    assign frame_bad = !len_ok || packet[spi_frame_pkg::SYNC_BIT] || tail_bad
                       || (stray_edges != 5'h00);
    // stray edges do not block the command itself
    assign cmd_ok = len_ok && !packet[spi_frame_pkg::SYNC_BIT] && !tail_bad
                    && (crc_ok || !CRC_CHECK_EN);
    assign crc_bad = CRC_CHECK_EN && ((len_ok && !crc_ok) || spurious);
    assign cmd.write = (packet[spi_frame_pkg::RW_BIT] == spi_frame_pkg::RW_WRITE);
    assign cmd.addr = packet[spi_frame_pkg::ADDR_LSB +: 6];
    assign cmd.data = packet[7:0];

    // power-up format counts strays so the first bus transaction is noticed
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            format <= spi_frame_pkg::FMT_POWERUP;
        end else if (frame_end && len_ok) begin
            format <= new_format;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settle window: a stray edge soon after deselect drops the command

    spi_frame_pkg::link_state_type link_state;
    spi_frame_pkg::command_type pending;
    logic pending_ok;
    logic discard;
    logic [SETTLE_W-1:0] settle_count;
    logic load;
    logic drop;
    logic commit_write;
    logic commit_read;

    assign load = (link_state == spi_frame_pkg::LINK_SETTLE) && (frame_start || settle_count == SETTLE_LAST);
    assign drop = discard || stray_fall;
    assign commit_write = load && pending_ok && !drop && pending.write;
    assign commit_read = load && pending_ok && !drop && !pending.write;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            link_state <= spi_frame_pkg::LINK_IDLE;
            pending <= '0;
            pending_ok <= 1'b0;
            discard <= 1'b0;
            settle_count <= '0;
        end else begin
            case (link_state)
                spi_frame_pkg::LINK_IDLE: begin
                    if (frame_start) begin
                        link_state <= spi_frame_pkg::LINK_FRAME;
                    end
                end
                spi_frame_pkg::LINK_FRAME: begin
                    if (frame_end) begin
                        link_state <= spi_frame_pkg::LINK_SETTLE;
                        pending <= cmd;
                        pending_ok <= cmd_ok;
                        discard <= 1'b0;
                        settle_count <= SETTLE_LOAD;
                    end
                end
                spi_frame_pkg::LINK_SETTLE: begin
                    if (load) begin
                        link_state <= frame_start ? spi_frame_pkg::LINK_FRAME : spi_frame_pkg::LINK_IDLE;
                    end else begin
                        settle_count <= settle_count - SETTLE_LAST;
                        if (stray_fall) begin
                            discard <= 1'b1;
                        end
                    end
                end
                default: begin
                    link_state <= spi_frame_pkg::LINK_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // error status word

    logic [11:0] flags;
    logic [11:0] flag_set;
    logic [11:0] flag_clear;

    always_comb begin
        flag_set = FLAG_EVENTS;
        flag_clear = 12'h000;
        if (frame_end && frame_bad) begin
            flag_set[spi_frame_pkg::IER_BIT] = 1'b1;
        end
        if (frame_end && crc_bad) begin
            flag_set[spi_frame_pkg::CRC_FLAG_BIT] = 1'b1;
        end
        if (commit_write && pending.addr == spi_frame_pkg::ERROR_STATUS_HI_ADDR) begin
            flag_clear[11:8] = pending.data[3:0];
        end
        if (commit_write && pending.addr == spi_frame_pkg::ERROR_STATUS_LO_ADDR) begin
            flag_clear[7:0] = pending.data;
        end
    end

    // a new event wins over a write-one-to-clear in the same cycle
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            flags <= spi_frame_pkg::FLAGS_RESET;
        end else begin
            flags <= (flags & ~flag_clear) | flag_set;
        end
    end

    assign ERROR_STATUS = {REGISTER_ID, flags};
    assign FRAMING_ERROR = flags[spi_frame_pkg::IER_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // response path

    logic [5:0] read_addr;
    logic [5:0] next_read_addr;
    logic [15:0] read_word;
    logic [3:0] read_crc;
    logic [20:0] tx;
    logic shift_tx;

    // a dropped read leaves the last valid address in place
    assign next_read_addr = commit_read ? pending.addr : read_addr;
    assign read_word = (next_read_addr[5:1] == spi_frame_pkg::ERROR_STATUS_HI_ADDR[5:1])
                       ? ERROR_STATUS : 16'h0000;
    assign read_crc = spi_frame_pkg::crc4(read_word);
    // 16-bit mode keeps shifting while deselected, which is how a stray edge corrupts the reply
    assign shift_tx = fall && (selected || (format == spi_frame_pkg::FMT_16 && cs_n_s && cs_d));

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            read_addr <= spi_frame_pkg::NOP_ADDR;
        end else if (commit_read) begin
            read_addr <= pending.addr;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            tx <= 21'h000000;
        end else if (load) begin
            tx <= {read_word, read_crc, read_crc[3]};
        end else if (shift_tx) begin
            tx <= {tx[19:0], 1'b0};
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            MISO <= 1'b0;
        end else if (selected && fall) begin
            MISO <= tx[20];
        end
    end

    assign MISO_OE = selected;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // age of the settle window kept apart from settle_count, so the length check does not copy it
    logic [SETTLE_W-1:0] settle_age;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            settle_age <= '0;
        end else if (link_state == spi_frame_pkg::LINK_SETTLE) begin
            settle_age <= settle_age + SETTLE_LAST;
        end else begin
            settle_age <= '0;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    framing_flag_a: assert property (frame_end && frame_bad |=> flags[spi_frame_pkg::IER_BIT])
        else $error("bad frame did not raise the framing flag");
    lead_bit_a: assert property (frame_end && len_ok && packet[15] |=> FRAMING_ERROR)
        else $error("leading one did not raise the framing flag");
    status_id_a: assert property (ERROR_STATUS[15:12] == REGISTER_ID)
        else $error("identifier field changed");
    stray_count_a: assert property (stray_fall && stray_edges == 5'h00 |=> stray_edges != 5'h00)
        else $error("stray edge not counted");
    ignore_21_a: assert property (fall && cs_n_s && cs_d && format == spi_frame_pkg::FMT_21
                                  |=> $stable(stray_edges))
        else $error("stray edge counted in 21-bit mode");
    early_drop_a: assert property (link_state == spi_frame_pkg::LINK_SETTLE && stray_fall && !load
                                   |=> discard [*1] ##0 !commit_write)
        else $error("early stray edge did not drop the command");
    reply_crc_a: assert property (load |=> tx[4:1] == spi_frame_pkg::crc4(tx[20:5]) && tx[0] == tx[4])
        else $error("reply checksum or repeat bit wrong");
    nop_read_a: assert property (load && next_read_addr == spi_frame_pkg::NOP_ADDR
                                 |=> tx[20:5] == 16'h0000)
        else $error("address zero did not read as zero");
    power_crc_a: assert property (frame_end && spurious && CRC_CHECK_EN
                                  |=> flags[spi_frame_pkg::CRC_FLAG_BIT] && FRAMING_ERROR)
        else $error("power-on spurious frame missed the checksum flag");
    miso_order_a: assert property (selected && fall |=> MISO == $past(tx[20]))
        else $error("reply bit order wrong");
    window_len_a: assert property (link_state == spi_frame_pkg::LINK_SETTLE && !frame_start
                                   |-> load == (settle_age == AGE_LAST))
        else $error("settle window length wrong");

    frame21_c: cover property (frame_end && new_format == spi_frame_pkg::FMT_21 && cmd_ok);
    dropped_c: cover property (load && drop && pending_ok);
    spurious_c: cover property (frame_end && spurious);
    corrupt16_c: cover property (shift_tx && cs_n_s && link_state == spi_frame_pkg::LINK_IDLE);
endmodule

// [spi_host_model.sv]
////////////////////////////////////////////////////////////////////////////////
// Purpose: host SPI master model sharing its clock line with other dies
// Assumes: SCLK idles high, MOSI set at each fall, MISO taken at each rise
// Notes: timing steps are whole CLOCK cycles so the bench stays deterministic
////////////////////////////////////////////////////////////////////////////////
module spi_host_model (
    input wire logic clock,
    input wire logic miso,
    output logic sclk,
    output logic cs_n,
    output logic mosi
);
    timeunit 1ns;
    timeprecision 100ps;

    // 80 ns half period gives the 160 ns link clock
    localparam int HALF = 16;

    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        mosi = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // one framed transfer; leading idle keeps the deselect gap above 20 cycles
    task automatic frame(input int len, input logic [20:0] tx, output logic [20:0] rx);
        rx = '0;
        tick(HALF);
        cs_n = 1'b0;
        tick(HALF);
        for (int i = len - 1; i >= 0; i--) begin
            sclk = 1'b0;
            mosi = tx[i];
            tick(HALF);
            sclk = 1'b1;
            rx = {rx[19:0], miso};
            tick(HALF);
        end
        cs_n = 1'b1;
        // released data line must not keep showing the last bit
        mosi = ~mosi;
        tick(8);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // clock pulse meant for another die while this one is deselected
    task automatic stray(input int lead);
        tick(lead);
        sclk = 1'b0;
        tick(HALF);
        sclk = 1'b1;
        tick(2 * HALF);
    endtask
endmodule

// [testbench.sv]
////////////////////////////////////////////////////////////////////////////////
// Purpose: self-checking bench for the SPI framing-error block
// Assumes: 200 MHz CLOCK; one die on a clock line shared with unseen dies
// Notes: reply of a read is checked in the frame that follows it
////////////////////////////////////////////////////////////////////////////////
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    // identifier value is arbitrary
    localparam logic [3:0] RID = 4'h5;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic crc_check_en = 1'b0;
    logic [11:0] flag_events = 12'h000;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic [15:0] error_status;
    logic framing_error;
    int num_errors = 0;
    int n_checks = 0;
    logic [20:0] rx;

    always #2.5 clock = ~clock;

    spi_frame_error_detect #(.REGISTER_ID(RID)) spi_frame_error_detect_i (
        .CLOCK(clock), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n), .MOSI(mosi),
        .CRC_CHECK_EN(crc_check_en), .FLAG_EVENTS(flag_events), .MISO(miso),
        .MISO_OE(miso_oe), .ERROR_STATUS(error_status), .FRAMING_ERROR(framing_error)
    );

    spi_host_model host_i (.clock(clock), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] ref_crc(input logic [15:0] w);
        logic [3:0] c;
        c = 4'hf;
        for (int i = 15; i >= 0; i--) begin
            c = {c[2:0], 1'b0} ^ ((c[3] ^ w[i]) ? 4'h3 : 4'h0);
        end
        return c;
    endfunction

    function automatic logic [20:0] rep(input int len, input logic [15:0] s);
        logic [3:0] c;
        c = ref_crc(s);
        if (len == 16) begin
            return {5'h00, s};
        end
        return (len == 20) ? {1'b0, s, c} : {s, c, c[3]};
    endfunction

    task automatic check(input logic [20:0] got, input logic [20:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic xfer(input int len, input logic wr, input logic [5:0] a, input logic [7:0] d);
        logic [15:0] w;
        logic [20:0] tx;
        w = {1'b0, wr, a, d};
        tx = (len == 16) ? {5'h00, w} : (len == 20) ? {1'b0, w, ref_crc(w)} : {w, ref_crc(w), 1'b0};
        host_i.frame(len, tx, rx);
    endtask

    task automatic pulse(input logic [11:0] f);
        @(posedge clock);
        #1 flag_events = f;
        @(posedge clock);
        #1 flag_events = 12'h000;
    endtask

    // write-one-to-clear of both status bytes
    task automatic clear_all();
        xfer(20, 1'b1, 6'h24, 8'h0f);
        xfer(20, 1'b1, 6'h25, 8'hff);
        host_i.tick(24);
        check(error_status, {RID, 12'h000}, "status after clear");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic s_reset();
        check(error_status, {RID, 12'h000}, "reset status");
        check(miso_oe, 1'b0, "reset oe");
    endtask

    task automatic s_powerup();
        crc_check_en = 1'b1;
        host_i.stray(4);
        xfer(20, 1'b0, 6'h00, 8'h00);
        check(framing_error, 1'b1, "power-on framing");
        check(error_status[9], 1'b1, "status bit 9");
        check(error_status[8], 1'b1, "power-on crc flag");
        clear_all();
        xfer(20, 1'b0, 6'h24, 8'h00);
        xfer(20, 1'b0, 6'h00, 8'h00);
        check(rx, rep(20, {RID, 12'h000}), "read after power-on");
        check(framing_error, 1'b0, "later frames clean");
    endtask

    task automatic s_bad_frames();
        host_i.frame(16, 21'h008000, rx);
        check(framing_error, 1'b1, "leading one");
        clear_all();
        host_i.frame(18, 21'h000000, rx);
        check(framing_error, 1'b1, "wrong length");
        clear_all();
        pulse(12'h002);
        host_i.frame(20, {1'b0, 16'h6502, ~ref_crc(16'h6502)}, rx);
        host_i.tick(24);
        check(error_status[9:8], 2'b01, "bad crc flag");
        check(error_status[1], 1'b1, "bad crc drops write");
        crc_check_en = 1'b0;
        host_i.frame(20, {1'b0, 16'h6502, ~ref_crc(16'h6502)}, rx);
        host_i.tick(24);
        check(error_status[1], 1'b0, "crc off keeps write");
        clear_all();
    endtask

    task automatic s_21bit();
        pulse(12'h0a5);
        xfer(21, 1'b0, 6'h25, 8'h00);
        host_i.stray(20);
        host_i.stray(0);
        xfer(21, 1'b0, 6'h00, 8'h00);
        check(rx, rep(21, {RID, 12'h0a5}), "21-bit reply");
        check(rx[4:1], ref_crc(rx[20:5]), "21-bit reply crc");
        check(framing_error, 1'b0, "strays ignored");
        fork
            xfer(21, 1'b0, 6'h00, 8'h00);
            begin
                host_i.tick(40);
                check(miso_oe, 1'b1, "oe while selected");
            end
        join
        check(rx, rep(21, 16'h0000), "nop reply");
        check(miso_oe, 1'b0, "oe after deselect");
    endtask

    task automatic s_20late();
        xfer(20, 1'b0, 6'h24, 8'h00);
        host_i.stray(20);
        xfer(20, 1'b0, 6'h00, 8'h00);
        check(rx, rep(20, {RID, 12'h0a5}), "20-bit late stray read");
        check(framing_error, 1'b1, "20-bit stray flag");
        clear_all();
    endtask

    task automatic s_16early();
        pulse(12'h003);
        xfer(16, 1'b0, 6'h24, 8'h00);
        xfer(16, 1'b0, 6'h00, 8'h00);
        host_i.stray(0);
        xfer(16, 1'b0, 6'h00, 8'h00);
        check(rx, rep(16, {RID, 12'h003}), "dropped read keeps last");
        check(framing_error, 1'b1, "16-bit stray flag");
        clear_all();
    endtask

    task automatic s_writes();
        pulse(12'h001);
        xfer(16, 1'b1, 6'h25, 8'h01);
        host_i.stray(0);
        check(error_status[0], 1'b1, "early stray drops write");
        xfer(16, 1'b1, 6'h25, 8'h01);
        host_i.stray(20);
        check(error_status[0], 1'b0, "late stray keeps write");
        xfer(16, 1'b0, 6'h00, 8'h00);
        check(framing_error, 1'b1, "flag after late write");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (num_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clock);
        #1 rst_n = 1'b1;
        s_reset();
        s_powerup();
        s_bad_frames();
        s_21bit();
        s_20late();
        s_16early();
        s_writes();
        tally_and_finish();
    end

    initial begin
        repeat (100000) @(posedge clock);
        num_errors++;
        $display("[ERR] %0t run did not finish", $time);
        tally_and_finish();
    end
endmodule
